/* File: rtl/rvcb_bank.sv */
`timescale 1ns/10ps
// Summary of operation
// - ldo one code at 42h, reset 10h
// - ldo two code at 43h, reset 10h
// - ldo three code at 44h, reset 24h
// - ldo four code at 45h, reset 24h
// - ldo code linear from 1.00V, 50mV
// - ldo codes 2Eh upward give 3.30V
// - converter codes step 12.5mV each
// - converter codes D8h upward give 3.3V
// - converter normal code at 40h, reset 30h
// - converter scaled code at 41h, reset 30h
module rvcb_bank
  import rvcb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic CONV_SCALE_SEL,
  output logic [5:0] LDO_ONE_CODE,
  output logic [5:0] LDO_TWO_CODE,
  output logic [5:0] LDO_THREE_CODE,
  output logic [5:0] LDO_FOUR_CODE,
  output logic [7:0] CONV_CODE,
  output logic [11:0] LDO_ONE_MV,
  output logic [15:0] CONV_UV100
);
  logic [7:0] conv_norm_q;
  logic [7:0] conv_scaled_q;
  logic [5:0] ldo1_q;
  logic [5:0] ldo2_q;
  logic [5:0] ldo3_q;
  logic [5:0] ldo4_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic sel_q;
  // scaling select is a pin, so two flops before use
  logic sel_q1;
  logic [7:0] conv_code_q;
  logic [7:0] conv_code_d;
  logic [5:0] wr_field;
  wire hit_cn = REG_WR && (REG_ADDR == CONV_NORMAL_ADDR);
  wire hit_cs = REG_WR && (REG_ADDR == CONV_SCALED_ADDR);
  wire hit_l1 = REG_WR && (REG_ADDR == LDO_ONE_ADDR);
  wire hit_l2 = REG_WR && (REG_ADDR == LDO_TWO_ADDR);
  wire hit_l3 = REG_WR && (REG_ADDR == LDO_THREE_ADDR);
  wire hit_l4 = REG_WR && (REG_ADDR == LDO_FOUR_ADDR);
  // spare bits dropped on write
  assign wr_field = REG_WDATA[LDO_FIELD_LSB +: LDO_FIELD_WIDTH];
  // unmapped addresses read zero
  assign rdata_d =
    (REG_ADDR == CONV_NORMAL_ADDR) ? conv_norm_q :
    (REG_ADDR == CONV_SCALED_ADDR) ? conv_scaled_q :
    (REG_ADDR == LDO_ONE_ADDR) ? {2'h0, ldo1_q} :
    (REG_ADDR == LDO_TWO_ADDR) ? {2'h0, ldo2_q} :
    (REG_ADDR == LDO_THREE_ADDR) ? {2'h0, ldo3_q} :
    (REG_ADDR == LDO_FOUR_ADDR) ? {2'h0, ldo4_q} : 8'h00;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      conv_norm_q <= CONV_RESET;
      conv_scaled_q <= CONV_RESET;
      ldo1_q <= LDO_ONE_RESET;
      ldo2_q <= LDO_TWO_RESET;
      ldo3_q <= LDO_THREE_RESET;
      ldo4_q <= LDO_FOUR_RESET;
      rdata_q <= 8'h00;
      sel_q <= 1'b0;
      sel_q1 <= 1'b0;
      conv_code_q <= CONV_RESET;
    end else begin
      if (hit_cn) conv_norm_q <= REG_WDATA;
      if (hit_cs) conv_scaled_q <= REG_WDATA;
      if (hit_l1) ldo1_q <= wr_field;
      if (hit_l2) ldo2_q <= wr_field;
      if (hit_l3) ldo3_q <= wr_field;
      if (hit_l4) ldo4_q <= wr_field;
      if (REG_RD) rdata_q <= rdata_d;
      sel_q1 <= CONV_SCALE_SEL;
      sel_q <= sel_q1;
      conv_code_q <= conv_code_d;
    end
  end
  assign REG_RDATA = rdata_q;
  assign LDO_ONE_CODE = ldo1_q;
  assign LDO_TWO_CODE = ldo2_q;
  assign LDO_THREE_CODE = ldo3_q;
  assign LDO_FOUR_CODE = ldo4_q;
  // registered so the core never sees a glitch on a switch
  assign conv_code_d = sel_q ? conv_scaled_q : conv_norm_q;
  assign CONV_CODE = conv_code_q;
  // one decoder shared: ldo one and the active converter code
  rvcb_decode u_dec (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .ldo_code(ldo1_q),
    .conv_code(CONV_CODE),
    .ldo_mv(LDO_ONE_MV),
    .conv_uv100(CONV_UV100)
  );

  property p_ldo_spare;
    @(posedge REF_CLK) disable iff (SYS_RST)
    REG_RD && REG_ADDR >= LDO_ONE_ADDR && REG_ADDR <= LDO_FOUR_ADDR
      |=> REG_RDATA[7:6] == 2'h0;
  endproperty
  a_ldo_spare: assert property (p_ldo_spare)
    else $error("ldo spare bits nonzero");
  property p_ldo1_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_l1 |=> LDO_ONE_CODE == $past(REG_WDATA[5:0]);
  endproperty
  a_ldo1_wr: assert property (p_ldo1_wr)
    else $error("ldo one write lost");
  property p_ldo_sat;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (LDO_ONE_CODE >= 6'h2E) ##1 (LDO_ONE_CODE >= 6'h2E)
      |-> LDO_ONE_MV == 12'hCE4;
  endproperty
  a_ldo_sat: assert property (p_ldo_sat)
    else $error("ldo not saturated");
  property p_ldo_lin;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (LDO_ONE_CODE == 6'h10) ##1 (LDO_ONE_CODE == 6'h10)
      |-> LDO_ONE_MV == 12'h708;
  endproperty
  a_ldo_lin: assert property (p_ldo_lin)
    else $error("ldo 1.80V decode wrong");
  property p_conv_clamp;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CONV_CODE >= 8'hF4) ##1 (CONV_CODE >= 8'hF4)
      |-> CONV_UV100 == 16'h80E8;
  endproperty
  a_conv_clamp: assert property (p_conv_clamp)
    else $error("converter not clamped");
  property p_conv_step;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CONV_CODE == 8'h74) ##1 (CONV_CODE == 8'h74)
      |-> CONV_UV100 == 16'h5014;
  endproperty
  a_conv_step: assert property (p_conv_step)
    else $error("converter 2.05V decode wrong");
  property p_conv_norm;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_cn && !hit_cs |=> conv_norm_q == $past(REG_WDATA);
  endproperty
  a_conv_norm: assert property (p_conv_norm)
    else $error("converter normal write lost");
  property p_conv_scaled;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_cs |=> conv_scaled_q == $past(REG_WDATA);
  endproperty
  a_conv_scaled: assert property (p_conv_scaled)
    else $error("converter scaled write lost");
  property p_ldo2_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_l2 |=> LDO_TWO_CODE == $past(REG_WDATA[5:0]);
  endproperty
  a_ldo2_wr: assert property (p_ldo2_wr)
    else $error("ldo two write lost");
  property p_ldo3_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_l3 |=> LDO_THREE_CODE == $past(REG_WDATA[5:0]);
  endproperty
  a_ldo3_wr: assert property (p_ldo3_wr)
    else $error("ldo three write lost");
  property p_ldo4_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    hit_l4 |=> LDO_FOUR_CODE == $past(REG_WDATA[5:0]);
  endproperty
  a_ldo4_wr: assert property (p_ldo4_wr)
    else $error("ldo four write lost");
  // reset checks run without disable, reset is their trigger
  property p_ldo_reset;
    @(posedge REF_CLK)
    SYS_RST |=> LDO_ONE_CODE == LDO_ONE_RESET &&
      LDO_TWO_CODE == LDO_TWO_RESET &&
      LDO_THREE_CODE == LDO_THREE_RESET &&
      LDO_FOUR_CODE == LDO_FOUR_RESET;
  endproperty
  a_ldo_reset: assert property (p_ldo_reset)
    else $error("ldo code not at reset value");
  property p_conv_reset;
    @(posedge REF_CLK)
    SYS_RST |=> conv_norm_q == CONV_RESET && conv_scaled_q == CONV_RESET;
  endproperty
  a_conv_reset: assert property (p_conv_reset)
    else $error("converter code not at reset value");
  // decoder output trails the code by one cycle, hence the ##1
  property p_ldo_base;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (LDO_ONE_CODE == 6'h00) ##1 (LDO_ONE_CODE == 6'h00)
      |-> LDO_ONE_MV == 12'h3E8;
  endproperty
  a_ldo_base: assert property (p_ldo_base)
    else $error("ldo 1.00V decode wrong");
  property p_conv_base;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CONV_CODE == 8'h34) ##1 (CONV_CODE == 8'h34)
      |-> CONV_UV100 == 16'h30D4;
  endproperty
  a_conv_base: assert property (p_conv_base)
    else $error("converter 1.25V decode wrong");
  property p_pick_scaled;
    @(posedge REF_CLK) disable iff (SYS_RST)
    sel_q |=> CONV_CODE == $past(conv_scaled_q);
  endproperty
  a_pick_scaled: assert property (p_pick_scaled)
    else $error("scaled code not selected");
  property p_pick_norm;
    @(posedge REF_CLK) disable iff (SYS_RST)
    !sel_q |=> CONV_CODE == $past(conv_norm_q);
  endproperty
  a_pick_norm: assert property (p_pick_norm)
    else $error("normal code not selected");
  property p_rd_unmapped;
    @(posedge REF_CLK) disable iff (SYS_RST)
    REG_RD && (REG_ADDR < CONV_NORMAL_ADDR || REG_ADDR > LDO_FOUR_ADDR)
      |=> REG_RDATA == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_rd_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
endmodule : rvcb_bank

/* File: rtl/rvcb_pkg.sv */
package rvcb_pkg;
  localparam logic [7:0] CONV_NORMAL_ADDR = 8'h40;
  localparam logic [7:0] CONV_SCALED_ADDR = 8'h41;
  localparam logic [7:0] LDO_ONE_ADDR = 8'h42;
  localparam logic [7:0] LDO_TWO_ADDR = 8'h43;
  localparam logic [7:0] LDO_THREE_ADDR = 8'h44;
  localparam logic [7:0] LDO_FOUR_ADDR = 8'h45;
  localparam logic [7:0] CONV_RESET = 8'h30;
  localparam logic [5:0] LDO_ONE_RESET = 6'h10;
  localparam logic [5:0] LDO_TWO_RESET = 6'h10;
  localparam logic [5:0] LDO_THREE_RESET = 6'h24;
  localparam logic [5:0] LDO_FOUR_RESET = 6'h24;
  localparam int LDO_FIELD_LSB = 0;
  localparam int LDO_FIELD_WIDTH = 6;
  // ldo target in mV: 1000 + 50 * code, saturating
  localparam logic [11:0] LDO_BASE_MV = 12'h3E8;
  localparam logic [11:0] LDO_STEP_MV = 12'h032;
  localparam logic [5:0] LDO_SAT_CODE = 6'h2E;
  localparam logic [11:0] LDO_MAX_MV = 12'hCE4;
  // converter target in 0.1 mV: 6000 + 125 * code, clamped
  // line reaches 3.3V at D8h; codes past it must not overshoot
  localparam logic [15:0] CONV_BASE_UV100 = 16'h1770;
  localparam logic [15:0] CONV_STEP_UV100 = 16'h007D;
  localparam logic [7:0] CONV_SAT_CODE = 8'hD8;
  localparam logic [15:0] CONV_MAX_UV100 = 16'h80E8;
endpackage : rvcb_pkg

/* File: rtl/rvcb_decode.sv */
`timescale 1ns/10ps
module rvcb_decode
  import rvcb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [5:0] ldo_code,
  input wire logic [7:0] conv_code,
  output logic [11:0] ldo_mv,
  output logic [15:0] conv_uv100
);
  logic [11:0] ldo_lin;
  logic [15:0] conv_lin;
  logic [11:0] ldo_mv_d;
  logic [15:0] conv_uv100_d;
  assign ldo_lin = LDO_BASE_MV + LDO_STEP_MV * {6'h00, ldo_code};
  assign ldo_mv_d = (ldo_code >= LDO_SAT_CODE) ? LDO_MAX_MV : ldo_lin;
  assign conv_lin = CONV_BASE_UV100 + CONV_STEP_UV100 * {8'h00, conv_code};
  assign conv_uv100_d = (conv_code >= CONV_SAT_CODE) ?
    CONV_MAX_UV100 : conv_lin;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ldo_mv <= 12'h000;
      conv_uv100 <= 16'h0000;
    end else begin
      ldo_mv <= ldo_mv_d;
      conv_uv100 <= conv_uv100_d;
    end
  end
endmodule : rvcb_decode

/* File: verif/rvcb_host.sv */
`timescale 1ns/10ps
module rvcb_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    // released bus shows a changed value, not the old one
    wdata = ~d;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : get
endmodule : rvcb_host

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import rvcb_pkg::*;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic sel = 1'b0;
  logic wr, rd;
  logic [7:0] addr, wdata, rdata, cc, q;
  logic [5:0] c1, c2, c3, c4;
  logic [11:0] mv;
  logic [15:0] uv;
  logic [7:0] lc[5] = '{8'h00, 8'h01, 8'h10, 8'h2D, 8'h2E};
  logic [15:0] le[5] = '{16'h03E8, 16'h041A, 16'h0708, 16'h0CB2, 16'h0CE4};
  logic [7:0] vc[8] = '{8'h33, 8'h34, 8'h74, 8'hB4, 8'hD9, 8'hF3, 8'hF4,
    8'hFF};
  // converter targets in 0.1 mV; past D8h held at 3.3V
  logic [15:0] ve[8] = '{16'h3057, 16'h30D4, 16'h5014, 16'h6F54, 16'h80E8,
    16'h80E8, 16'h80E8, 16'h80E8};
  int n_fail = 0;
  int num_checks = 0;
  always #5 REF_CLK = ~REF_CLK;
  rvcb_bank dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .CONV_SCALE_SEL(sel), .LDO_ONE_CODE(c1), .LDO_TWO_CODE(c2),
    .LDO_THREE_CODE(c3), .LDO_FOUR_CODE(c4), .CONV_CODE(cc),
    .LDO_ONE_MV(mv), .CONV_UV100(uv));
  rvcb_host host (.clk(REF_CLK), .rdata(rdata), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.get(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask : rchk
  task results;
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    repeat (6) @(negedge REF_CLK);
    SYS_RST = 1'b0;
    rchk(8'h40, 8'h30);
    rchk(8'h41, 8'h30);
    rchk(8'h42, 8'h10);
    rchk(8'h43, 8'h10);
    rchk(8'h44, 8'h24);
    rchk(8'h45, 8'h24);
    rchk(8'h46, 8'h00);
    host.put(8'h42, 8'hFF);
    rchk(8'h42, 8'h3F);
    chk({4'h0, mv}, 16'h0CE4);
    chk({10'h000, c1}, 16'h003F);
    host.put(8'h44, 8'hC1);
    chk({10'h000, c3}, 16'h0001);
    host.put(8'h43, 8'h3A);
    chk({10'h000, c2}, 16'h003A);
    host.put(8'h45, 8'h15);
    chk({10'h000, c4}, 16'h0015);
    foreach (lc[i]) begin
      host.put(8'h42, lc[i]);
      repeat (2) @(negedge REF_CLK);
      chk({4'h0, mv}, le[i]);
    end
    foreach (vc[i]) begin
      host.put(8'h40, vc[i]);
      repeat (2) @(negedge REF_CLK);
      chk({8'h00, cc}, {8'h00, vc[i]});
      chk(uv, ve[i]);
    end
    host.put(8'h41, 8'hB4);
    sel = 1'b1;
    repeat (5) @(negedge REF_CLK);
    chk({8'h00, cc}, 16'h00B4);
    chk(uv, 16'h6F54);
    // mid-run reset must restore every code
    SYS_RST = 1'b1;
    repeat (2) @(negedge REF_CLK);
    SYS_RST = 1'b0;
    rchk(8'h40, 8'h30);
    rchk(8'h41, 8'h30);
    rchk(8'h42, 8'h10);
    rchk(8'h44, 8'h24);
    chk({10'h000, c2}, 16'h0010);
    chk({10'h000, c4}, 16'h0024);
    chk({4'h0, mv}, 16'h0708);
    chk({8'h00, cc}, 16'h0030);
    chk(uv, 16'h2EE0);
    results();
  end
endmodule : tb_top
